// ===== core/sorter_port.sv
// Sorter handshake port: trigger capture, sequencing and bin output drive
// Assumes a measurement core that reports conversion end and result ready
//
// How it works
// - Trigger in, conversion done, measurement done
// - Result lines are open-collector, pulled low
// - One pass bin, or fail, or aux
// - Reject cause on high, low, secondary lines
// - Control lines open-collector, pulled low
// - Conversion done asserts when analog ends
// - Measurement done only together with valid bins, in the same cycle
// - Selectable trigger edge, rising by default
// - One trigger remembered during a measurement
// - Setup wait 200us to 2ms plus delay
`timescale 1ns/10ps
`include "sorter_port_cfg.svh"

module sp_sorter_port
(
  // Clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 nrst_i,
  // Sorter_port side trigger pin, active low line level
  input  wire logic                 start_test_in_n_i,
  // Configuration
  input  wire logic                 start_test_in_edge_fall_i,
  input  wire logic [31:0]          step_delay_cyc_i,
  // Measurement core
  output logic                      meas_start_o,
  input  wire logic                 analog_done_i,
  input  wire logic                 result_valid_i,
  input  wire sp_pkg::sp_result_s   result_i,
  // Sorter_port side outputs, low active, enable high while pulled
  output logic                      conversion_done_out_n_o,
  output logic                      conversion_done_out_oe_o,
  output logic                      measurement_done_out_n_o,
  output logic                      measurement_done_out_oe_o,
  output sp_pkg::sp_sort_s          sort_n_o,
  output sp_pkg::sp_sort_s          sort_oe_o
);
  import sp_pkg::*;

  localparam logic [31:0] SETUP_MIN = 32'(`SP_SETUP_MIN_CYC);
  localparam logic [31:0] SETUP_MAX = 32'(`SP_SETUP_MAX_CYC);

  sp_state_e   state;
  logic [2:0]  start_test_in_sync;
  logic        start_test_in_level;
  logic        start_test_in_prev;
  logic        start_test_in_pend;
  logic [31:0] setup_cnt;
  logic        start_test_in_evt;
  logic        start_now;

  function automatic sp_sort_s encode_sort(input sp_result_s r);
    sp_sort_s s;
    s = '1;
    if (r.fail)
    begin
      s.fail_n             = 1'b0;
      s.primary_high_n     = ~r.pri_high;
      s.primary_low_n      = ~r.pri_low;
      s.secondary_reject_n = ~r.sec_rej;
    end
    else if (r.aux)
      s.aux_n = 1'b0;
    else if (r.bin_num >= 4'h1 && r.bin_num <= 4'h9)
      s.pass_bin_n[r.bin_num - 4'h1] = 1'b0;
    else
      s.fail_n = 1'b0;
    return s;
  endfunction

  // Three-stage pin synchroniser; level changes once stages two and three agree
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      start_test_in_sync <= 3'h7;
    else
      start_test_in_sync <= {start_test_in_sync[1:0], start_test_in_n_i};
  end

  // Pin is low-driven by the controller, so the logical level is inverted
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      start_test_in_level <= 1'b0;
      start_test_in_prev  <= 1'b0;
    end
    else
    begin
      if (start_test_in_sync[1] == start_test_in_sync[2])
        start_test_in_level <= ~start_test_in_sync[2];
      start_test_in_prev <= start_test_in_level;
    end
  end

  // Pulse width is the controller's duty; no width filter here
  assign start_test_in_evt = start_test_in_edge_fall_i ? (start_test_in_prev & ~start_test_in_level)
                                     : (~start_test_in_prev & start_test_in_level);
  assign start_now = (state == SP_IDLE || state == SP_DONE) && (start_test_in_evt || start_test_in_pend);

  // Single-deep trigger memory; further triggers while busy are dropped
  // An edge landing as the remembered one starts is kept, not lost
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      start_test_in_pend <= 1'b0;
    else if (start_now)
      start_test_in_pend <= start_test_in_pend & start_test_in_evt;
    else if (start_test_in_evt)
      start_test_in_pend <= 1'b1;
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      state     <= SP_IDLE;
      setup_cnt <= '0;
    end
    else
    begin
      case (state)
        SP_IDLE, SP_DONE:
        begin
          if (start_now)
          begin
            state     <= SP_SETUP;
            setup_cnt <= '0;
          end
        end
        SP_SETUP:
        begin
          setup_cnt <= setup_cnt + 32'h1;
          if (setup_cnt + 32'h1 >= SETUP_MIN + step_delay_cyc_i)
            state <= SP_CONVERT;
        end
        SP_CONVERT:
        begin
          if (analog_done_i)
            state <= SP_PROCESS;
        end
        SP_PROCESS:
        begin
          if (result_valid_i)
            state <= SP_DONE;
        end
        default:
          state <= SP_IDLE;
      endcase
    end
  end

  // Start pulse to the core at the end of setup
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      meas_start_o <= 1'b0;
    else
      meas_start_o <= (state == SP_SETUP) &&
                      (setup_cnt + 32'h1 >= SETUP_MIN + step_delay_cyc_i);
  end

  // Control outputs
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      conversion_done_out_oe_o  <= 1'b0;
      measurement_done_out_oe_o <= 1'b0;
    end
    else if (start_now)
    begin
      conversion_done_out_oe_o  <= 1'b0;
      measurement_done_out_oe_o <= 1'b0;
    end
    else
    begin
      if (state == SP_CONVERT && analog_done_i)
        conversion_done_out_oe_o <= 1'b1;
      if (state == SP_PROCESS && result_valid_i)
        measurement_done_out_oe_o <= 1'b1;
    end
  end

  // Open collector: line value is low whenever pulled
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      conversion_done_out_n_o  <= 1'b0;
      measurement_done_out_n_o <= 1'b0;
    end
    else
    begin
      conversion_done_out_n_o  <= 1'b0;
      measurement_done_out_n_o <= 1'b0;
    end
  end

  // Result lines; bins written the same cycle measurement done rises
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      sort_n_o  <= '0;
      sort_oe_o <= '0;
    end
    else if (start_now)
    begin
      sort_n_o  <= '0;
      sort_oe_o <= '0;
    end
    else if (state == SP_PROCESS && result_valid_i)
    begin
      sort_n_o  <= '0;
      sort_oe_o <= ~encode_sort(result_i);
    end
  end

  a_setup_bounds: assert property (@(posedge clk_i) disable iff (!nrst_i)
    $rose(meas_start_o) |-> $past(setup_cnt) + 32'h1 >= SETUP_MIN
      && $past(setup_cnt) < SETUP_MAX + step_delay_cyc_i)
    else $error("setup interval out of range");

  a_eom_after_bins: assert property (@(posedge clk_i) disable iff (!nrst_i)
    $rose(measurement_done_out_oe_o) |-> (sort_oe_o != '0))
    else $error("measurement done without a bin");

  a_one_pass_bin: assert property (@(posedge clk_i) disable iff (!nrst_i)
    measurement_done_out_oe_o |-> $onehot0({sort_oe_o.pass_bin_n, sort_oe_o.fail_n,
      sort_oe_o.aux_n}) && (sort_oe_o.pass_bin_n != '0 || sort_oe_o.fail_n
      || sort_oe_o.aux_n))
    else $error("verdict not exactly one");

  a_cause_only_fail: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (sort_oe_o.primary_high_n || sort_oe_o.primary_low_n || sort_oe_o.secondary_reject_n)
      |-> sort_oe_o.fail_n)
    else $error("reject cause without fail");

  a_start_release: assert property (@(posedge clk_i) disable iff (!nrst_i)
    start_now |=> !measurement_done_out_oe_o && !conversion_done_out_oe_o
      && sort_oe_o == '0)
    else $error("outputs not released at start");

  a_idx_before_eom: assert property (@(posedge clk_i) disable iff (!nrst_i)
    measurement_done_out_oe_o |-> conversion_done_out_oe_o)
    else $error("measurement done before conversion done");

  a_pending_kept: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (start_test_in_evt && state == SP_CONVERT) |=> start_test_in_pend)
    else $error("trigger during measurement lost");

  a_lines_low: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !conversion_done_out_n_o && !measurement_done_out_n_o && sort_n_o == '0)
    else $error("open collector drives high");

  a_edge_start: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (state == SP_IDLE && !start_test_in_pend && !start_test_in_edge_fall_i && $rose(start_test_in_level))
      |=> state == SP_SETUP)
    else $error("rising edge did not start");

endmodule

// ===== core/sorter_port_cfg.svh
// Timing and field constants for the sorter handshake port
// Assumes a 125 MHz core clock
`ifndef SORTER_PORT_CFG_SVH
`define SORTER_PORT_CFG_SVH

`define SP_CLK_MHZ          125
`define SP_SETUP_MIN_US     200
`define SP_SETUP_MAX_US     2000
`define SP_SETUP_MIN_CYC    (`SP_SETUP_MIN_US * `SP_CLK_MHZ)
`define SP_SETUP_MAX_CYC    (`SP_SETUP_MAX_US * `SP_CLK_MHZ)
`define SP_BIN_COUNT        9
`define SP_EDGE_RISE        1'b0
`define SP_CNT_W            32
`define SP_BINS_RELEASED    9'h1ff

`endif

// ===== core/sorter_port_pkg.sv
// Types shared by the sorter handshake port
// Pairs with sorter_port_cfg.svh for numeric constants
package sp_pkg;

  typedef enum logic [2:0] {
    SP_IDLE    = 3'b000,
    SP_SETUP   = 3'b001,
    SP_CONVERT = 3'b010,
    SP_PROCESS = 3'b011,
    SP_DONE    = 3'b100
  } sp_state_e;

  // Sorting verdict from the measurement core
  typedef struct packed {
    logic [3:0] bin_num;
    logic       fail;
    logic       aux;
    logic       pri_high;
    logic       pri_low;
    logic       sec_rej;
  } sp_result_s;

  // Open-collector outputs, low while asserted
  typedef struct packed {
    logic [8:0] pass_bin_n;
    logic       fail_n;
    logic       aux_n;
    logic       primary_high_n;
    logic       primary_low_n;
    logic       secondary_reject_n;
  } sp_sort_s;

endpackage

// ===== tb/sp_sorter_port_model.sv
// Controller model: pulses the trigger line, latches bins after measurement done
// Assumes the bench resolves open-collector lines to their pull-up idle level
`timescale 1ns/10ps
module sp_sorter_port_model
(
  // Clock
  input  wire logic        clk_i,
  // Bench request for one trigger pulse
  input  wire logic        fire_i,
  // Port lines, line level
  output logic             start_test_in_n_o,
  input  wire logic        done_line_i,
  input  wire logic [13:0] sort_line_i,
  output logic [13:0]      sampled_o
);
  int   hold = 0;
  logic done_q = 1'b1;
  initial start_test_in_n_o = 1'b1;
  initial sampled_o = '0;
  always @(posedge clk_i)
  begin
    // Pulse kept a little over 10us at 8ns
    if (fire_i)
      hold <= 1260;
    else if (hold > 0)
      hold <= hold - 1;
    start_test_in_n_o <= !(fire_i || hold > 1);
    done_q <= done_line_i;
    // Bins read only once measurement done has fallen
    if (done_q && !done_line_i)
      sampled_o <= ~sort_line_i;
  end
endmodule

// ===== tb/tb_top.sv
// Bench for the sorter port: a pass measurement, a queued fail measurement,
// then an aux measurement started on the trailing trigger edge
// Assumes sp_sorter_port_model as the controller; the bench plays the measurement core
`timescale 1ns/10ps
`define CHK(nm, e, g) \
  begin compares++; if ((g) !== (e)) begin fail_count++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module tb_top;
  import sp_pkg::*;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        fire = 1'b0;
  logic        edge_fall = 1'b0;
  logic        adone = 1'b0;
  logic        rvalid = 1'b0;
  sp_result_s  result = '0;
  logic        start_test_in_n;
  logic        mstart;
  logic        conv_n;
  logic        conv_oe;
  logic        done_n;
  logic        done_oe;
  sp_sort_s    sort_n;
  sp_sort_s    sort_oe;
  logic [13:0] sort_line;
  logic [13:0] sampled;
  logic        conv_line;
  logic        done_line;
  int          fail_count = 0;
  int          compares = 0;
  always #4 clk = ~clk;
  // Released lines float to the pull-up level
  assign conv_line = conv_oe ? conv_n : 1'b1;
  assign done_line = done_oe ? done_n : 1'b1;
  assign sort_line = (sort_oe & sort_n) | ~sort_oe;
  sp_sorter_port dut_u
  (
    .clk_i                     (clk),
    .nrst_i                    (nrst),
    .start_test_in_n_i         (start_test_in_n),
    .start_test_in_edge_fall_i          (edge_fall),
    .step_delay_cyc_i          (32'h10),
    .meas_start_o              (mstart),
    .analog_done_i             (adone),
    .result_valid_i            (rvalid),
    .result_i                  (result),
    .conversion_done_out_n_o   (conv_n),
    .conversion_done_out_oe_o  (conv_oe),
    .measurement_done_out_n_o  (done_n),
    .measurement_done_out_oe_o (done_oe),
    .sort_n_o                  (sort_n),
    .sort_oe_o                 (sort_oe)
  );
  sp_sorter_port_model ctl_u
  (
    .clk_i       (clk),
    .fire_i      (fire),
    .start_test_in_n_o    (start_test_in_n),
    .done_line_i (done_line),
    .sort_line_i (sort_line),
    .sampled_o   (sampled)
  );
  task automatic cycles(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic measure(input string nm, input logic [8:0] r, input logic [13:0] exp,
                         input logic queue_next);
    int cnt;
    cnt = 0;
    while (mstart !== 1'b1 && cnt < 26000)
    begin
      @(posedge clk);
      cnt++;
    end
    `CHK("setup span", 1'b1, cnt >= 25010 && cnt <= 25030)
    `CHK("conv released", 1'b1, conv_line)
    `CHK("bins released", 15'h7fff, {sort_line, done_line})
    // Second trigger lands while this measurement runs
    if (queue_next)
    begin
      fire <= 1'b1;
      cycles(1);
      fire <= 1'b0;
      cycles(20);
    end
    adone <= 1'b1;
    cycles(1);
    adone <= 1'b0;
    cycles(1);
    `CHK("conv then done", 2'b01, {conv_line, done_line})
    result <= sp_result_s'(r);
    rvalid <= 1'b1;
    cycles(1);
    rvalid <= 1'b0;
    cycles(1);
    `CHK("meas done", 1'b0, done_line)
    `CHK("sort lines", ~exp, sort_line)
    cycles(1);
    `CHK("sampled", exp, sampled)
    $display("test %s done", nm);
  endtask
  task automatic summarize();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    cycles(90000);
    fail_count++;
    $display("watchdog expired");
    summarize();
  end
  initial
  begin
    cycles(20);
    nrst <= 1'b1;
    cycles(2);
    fire <= 1'b1;
    cycles(1);
    fire <= 1'b0;
    measure("pass_bin3", 9'h060, 14'h0080, 1'b1);
    // Started from the remembered trigger only
    measure("queued_fail_high", 9'h014, 14'h0014, 1'b0);
    // Trailing edge only: the leading edge must leave the last result standing
    edge_fall <= 1'b1;
    fire <= 1'b1;
    cycles(1);
    fire <= 1'b0;
    cycles(1262);
    `CHK("no start on lead", 1'b0, done_line)
    measure("fall_edge_aux", 9'h008, 14'h0008, 1'b0);
    summarize();
  end
endmodule
